// >>> design/sfm_params.svh
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH

// System clock rate and the framing loss interval
`define SFM_CLK_KHZ 20000
`define SFM_LOF_TIME_US 3000
// Cycles in the framing loss interval, rounded down
`define SFM_LOF_CYCLES ((`SFM_LOF_TIME_US * `SFM_CLK_KHZ) / 1000)

// Frame counts
`define SFM_LOF_CLR_FRAMES 4'h2
`define SFM_LOP_SET_FRAMES 4'h8
`define SFM_LOP_CLR_FRAMES 4'h3

// Port counts and concatenation width
`define SFM_NUM_LINE 2
`define SFM_NUM_REF 2
`define SFM_CONC_W 6

`endif

// >>> design/sfm_pkg.sv
package sfm_pkg;

    typedef enum logic [1:0] {
        SFM_PTR_NORM = 2'b01,
        SFM_PTR_LOP = 2'b10
    } sfm_ptr_state_type;

    typedef enum logic {
        SFM_CODE_AMI = 1'b0,
        SFM_CODE_B8ZS = 1'b1
    } sfm_coding_type;

    typedef enum logic {
        SFM_FRM_SF = 1'b0,
        SFM_FRM_ESF = 1'b1
    } sfm_framing_type;

endpackage : sfm_pkg

// >>> design/sfm_mon_if.sv
`timescale 1ns/1ps
interface sfm_mon_if;
    logic frame_stb;
    logic pat_ok;
    logic lof;
    modport src(output frame_stb, output pat_ok, input lof);
    modport mon(input frame_stb, input pat_ok, output lof);
endinterface : sfm_mon_if

// >>> design/sfm_frame_mon.sv
`timescale 1ns/1ps
`include "sfm_params.svh"
module sfm_frame_mon #(
    parameter int LOF_CYC = `SFM_LOF_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    sfm_mon_if.mon mif
);
    localparam int TW = $clog2(LOF_CYC + 1);
    localparam logic [TW-1:0] TMAX = TW'(LOF_CYC);

    logic [TW-1:0] timer;
    logic [3:0] good_cnt;
    logic lof;

    wire good_frame = mif.frame_stb & mif.pat_ok;
    wire timer_hit = (timer == TMAX - TW'(1)) & ~good_frame;
    wire clr_hit = good_frame & (good_cnt == `SFM_LOF_CLR_FRAMES - 4'h1);

    assign mif.lof = lof;

    // Timer restarts on each good pattern and saturates at the limit
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            timer <= '0;
        end else if (good_frame) begin
            timer <= '0; // [RL12]
        end else if (timer != TMAX) begin
            timer <= timer + TW'(1); // [RL12]
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lof <= 1'b0;
            good_cnt <= 4'h0;
        end else if (!lof) begin
            good_cnt <= 4'h0;
            if (timer_hit) begin
                lof <= 1'b1; // [RL1]
            end
        end else if (mif.frame_stb) begin
            // Any bad frame breaks the run of consecutive good ones
            if (clr_hit) begin
                lof <= 1'b0; // [RL2]
                good_cnt <= 4'h0;
            end else if (mif.pat_ok) begin
                good_cnt <= good_cnt + 4'h1; // [RL2]
            end else begin
                good_cnt <= 4'h0; // [RL2]
            end
        end
    end

endmodule : sfm_frame_mon

// >>> design/sfm_defect_monitor.sv
// Functional notes
// RL1: Declare line LOF after 3 ms without framing.
// RL2: Clear LOF on two consecutive good frames.
// RL3: Check pointer bytes in every received frame.
// RL4: Declare LOP after eight consecutive invalid pointers.
// RL5: Clear LOP after three consecutive valid pointers.
// RL6: Smaller received concatenation than provisioned is invalid.
// RL7: Each timing reference port detects LOF independently.
// RL8: Timing coding provisionable, B8ZS or AMI.
// RL9: Timing framing provisionable, ESF or SF.
// RL10: Flag coding and framing pairs not recommended.
// RL11: Line LOF on protected card requests switch.
// RL12: Count pointers in frames; timer resets on framing.
`timescale 1ns/1ps
`include "sfm_params.svh"
module sfm_defect_monitor #(
    parameter int NUM_LINE = `SFM_NUM_LINE,
    parameter int NUM_REF = `SFM_NUM_REF,
    parameter int CONC_W = `SFM_CONC_W,
    parameter int LOF_CYC = `SFM_LOF_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [NUM_LINE-1:0] line_frame_i,
    input wire logic [NUM_LINE-1:0] line_fas_ok_i,
    input wire logic [NUM_LINE-1:0] line_protected_i,
    input wire logic path_frame_i,
    input wire logic path_ptr_ok_i,
    input wire logic [CONC_W-1:0] path_rx_conc_i,
    input wire logic [CONC_W-1:0] path_prov_conc_i,
    input wire logic [NUM_REF-1:0] ref_frame_i,
    input wire logic [NUM_REF-1:0] ref_fas_ok_i,
    input wire logic [NUM_REF-1:0] ref_rx_b8zs_i,
    input wire logic [NUM_REF-1:0] ref_rx_esf_i,
    input wire logic prov_b8zs_i,
    input wire logic prov_esf_i,
    output logic [NUM_LINE-1:0] line_lof_o,
    output logic [NUM_LINE-1:0] line_aps_req_o,
    output logic path_lop_o,
    output logic path_conc_mismatch_o,
    output logic [NUM_REF-1:0] ref_lof_o,
    output logic [NUM_REF-1:0] ref_fmt_mismatch_o,
    output logic prov_pair_warn_o
);
    localparam int AW = 3 * NUM_LINE + 2 + 2 * CONC_W + 4 * NUM_REF + 2;
    localparam int FW = NUM_LINE + 1 + NUM_REF;

    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        sat_inc = (v == 4'hf) ? v : v + 4'h1;
    endfunction : sat_inc

    // Every input comes from the line or from software; all pass two stages
    wire [AW-1:0] async_in = {line_frame_i, line_fas_ok_i, line_protected_i,
                              path_frame_i, path_ptr_ok_i, path_rx_conc_i,
                              path_prov_conc_i, ref_frame_i, ref_fas_ok_i,
                              ref_rx_b8zs_i, ref_rx_esf_i, prov_b8zs_i, prov_esf_i};
    logic [AW-1:0] sync_a;
    logic [AW-1:0] sync_b;
    logic [FW-1:0] frame_d;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
        end
    end

    wire [NUM_LINE-1:0] s_line_frame;
    wire [NUM_LINE-1:0] s_line_fas_ok;
    wire [NUM_LINE-1:0] s_line_prot;
    wire s_path_frame;
    wire s_ptr_ok;
    wire [CONC_W-1:0] s_rx_conc;
    wire [CONC_W-1:0] s_prov_conc;
    wire [NUM_REF-1:0] s_ref_frame;
    wire [NUM_REF-1:0] s_ref_fas_ok;
    wire [NUM_REF-1:0] s_ref_b8zs;
    wire [NUM_REF-1:0] s_ref_esf;
    wire s_prov_b8zs;
    wire s_prov_esf;

    assign {s_line_frame, s_line_fas_ok, s_line_prot, s_path_frame, s_ptr_ok,
            s_rx_conc, s_prov_conc, s_ref_frame, s_ref_fas_ok, s_ref_b8zs,
            s_ref_esf, s_prov_b8zs, s_prov_esf} = sync_b;

    // Frame strobes are levels on the pins; one pulse per rising edge
    wire [FW-1:0] frame_lvl = {s_line_frame, s_path_frame, s_ref_frame};
    wire [FW-1:0] frame_rise = frame_lvl & ~frame_d;
    wire [NUM_LINE-1:0] line_stb = frame_rise[FW-1 -: NUM_LINE];
    wire path_stb = frame_rise[NUM_REF];
    wire [NUM_REF-1:0] ref_stb = frame_rise[NUM_REF-1:0];

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_d <= '0;
        end else begin
            frame_d <= frame_lvl;
        end
    end

    // Provisioned coding and framing for the timing references
    sfm_pkg::sfm_coding_type prov_code;
    sfm_pkg::sfm_framing_type prov_fmt;
    assign prov_code = s_prov_b8zs ? sfm_pkg::SFM_CODE_B8ZS : sfm_pkg::SFM_CODE_AMI; // [RL8]
    assign prov_fmt = s_prov_esf ? sfm_pkg::SFM_FRM_ESF : sfm_pkg::SFM_FRM_SF; // [RL9]
    wire pair_bad = (prov_code == sfm_pkg::SFM_CODE_B8ZS) != (prov_fmt == sfm_pkg::SFM_FRM_ESF);

    wire [NUM_REF-1:0] ref_fmt_ok;

    // Line ports
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINE; gi++) begin : g_line
            sfm_mon_if lif ();
            assign lif.frame_stb = line_stb[gi];
            assign lif.pat_ok = s_line_fas_ok[gi];
            assign line_lof_o[gi] = lif.lof;
            sfm_frame_mon #(
                .LOF_CYC(LOF_CYC)
            ) u_mon (
                .clk_sys_i(clk_sys_i),
                .rst_b_i(rst_b_i),
                .mif(lif.mon)
            ); // [RL1] [RL2]
        end

        // Timing reference ports, one monitor each
        for (gi = 0; gi < NUM_REF; gi++) begin : g_ref
            sfm_mon_if rif ();
            // A coding or framing the source does not share never frames
            assign ref_fmt_ok[gi] = (s_ref_b8zs[gi] == s_prov_b8zs) &
                                    (s_ref_esf[gi] == s_prov_esf); // [RL8] [RL9]
            assign rif.frame_stb = ref_stb[gi];
            assign rif.pat_ok = s_ref_fas_ok[gi] & ref_fmt_ok[gi];
            assign ref_lof_o[gi] = rif.lof;
            sfm_frame_mon #(
                .LOF_CYC(LOF_CYC)
            ) u_mon (
                .clk_sys_i(clk_sys_i),
                .rst_b_i(rst_b_i),
                .mif(rif.mon)
            ); // [RL7]
        end
    endgenerate

    // Mismatch flag keeps the verdict of the last frame seen on each reference
    wire [NUM_REF-1:0] next_ref_mismatch = (ref_fmt_mismatch_o & ~ref_stb) |
                                           (~ref_fmt_ok & ref_stb);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_fmt_mismatch_o <= '0;
        end else begin
            ref_fmt_mismatch_o <= next_ref_mismatch; // [RL8] [RL9]
        end
    end

    // Switch request and pairing advice
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_aps_req_o <= '0;
            prov_pair_warn_o <= 1'b0;
        end else begin
            line_aps_req_o <= line_lof_o & s_line_prot; // [RL11]
            prov_pair_warn_o <= pair_bad; // [RL10]
        end
    end

    // Pointer monitor, advanced once per received path frame
    wire conc_short = s_rx_conc < s_prov_conc;
    wire ptr_valid = s_ptr_ok & ~conc_short; // [RL6]

    sfm_pkg::sfm_ptr_state_type ptr_state;
    sfm_pkg::sfm_ptr_state_type next_ptr_state;
    logic [3:0] bad_cnt;
    logic [3:0] good_cnt;
    logic [3:0] next_bad_cnt;
    logic [3:0] next_good_cnt;

    always_comb begin
        next_ptr_state = ptr_state;
        next_bad_cnt = bad_cnt;
        next_good_cnt = good_cnt;
        case (ptr_state)
            sfm_pkg::SFM_PTR_NORM: begin
                next_good_cnt = 4'h0;
                if (ptr_valid) begin
                    next_bad_cnt = 4'h0; // [RL3]
                end else if (bad_cnt == `SFM_LOP_SET_FRAMES - 4'h1) begin
                    next_ptr_state = sfm_pkg::SFM_PTR_LOP; // [RL4]
                    next_bad_cnt = 4'h0;
                end else begin
                    next_bad_cnt = sat_inc(bad_cnt); // [RL4] [RL12]
                end
            end
            sfm_pkg::SFM_PTR_LOP: begin
                next_bad_cnt = 4'h0;
                if (!ptr_valid) begin
                    next_good_cnt = 4'h0; // [RL5]
                end else if (good_cnt == `SFM_LOP_CLR_FRAMES - 4'h1) begin
                    next_ptr_state = sfm_pkg::SFM_PTR_NORM; // [RL5]
                    next_good_cnt = 4'h0;
                end else begin
                    next_good_cnt = sat_inc(good_cnt); // [RL5] [RL12]
                end
            end
            default: begin
                next_ptr_state = sfm_pkg::SFM_PTR_NORM;
                next_bad_cnt = 4'h0;
                next_good_cnt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_state <= sfm_pkg::SFM_PTR_NORM;
            bad_cnt <= 4'h0;
            good_cnt <= 4'h0;
            path_lop_o <= 1'b0;
            path_conc_mismatch_o <= 1'b0;
        end else if (path_stb) begin
            ptr_state <= next_ptr_state; // [RL3]
            bad_cnt <= next_bad_cnt;
            good_cnt <= next_good_cnt;
            path_lop_o <= (next_ptr_state == sfm_pkg::SFM_PTR_LOP);
            path_conc_mismatch_o <= conc_short; // [RL6]
        end
    end

endmodule : sfm_defect_monitor

// >>> verification/sfm_defect_monitor_properties.sv
`timescale 1ns/1ps
module sfm_chk #(
    parameter int NUM_LINE = 2,
    parameter int CONC_W = 6,
    parameter int LOF_CYC = 50
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [NUM_LINE-1:0] line_frame_i,
    input wire logic [NUM_LINE-1:0] line_fas_ok_i,
    input wire logic [NUM_LINE-1:0] line_protected_i,
    input wire logic path_frame_i,
    input wire logic path_ptr_ok_i,
    input wire logic [CONC_W-1:0] path_rx_conc_i,
    input wire logic [CONC_W-1:0] path_prov_conc_i,
    input wire logic prov_b8zs_i,
    input wire logic prov_esf_i,
    input wire logic [NUM_LINE-1:0] line_lof_o,
    input wire logic [NUM_LINE-1:0] line_aps_req_o,
    input wire logic path_lop_o,
    input wire logic path_conc_mismatch_o,
    input wire logic prov_pair_warn_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic lf_q;
    logic pf_q;
    int gap;
    int lgood;
    int pbad;
    int pgood;
    wire l_frm = line_frame_i[0] & ~lf_q;
    wire p_frm = path_frame_i & ~pf_q;
    wire p_val = path_ptr_ok_i && (path_rx_conc_i >= path_prov_conc_i);
    // Counted at the pins, two cycles ahead of the design; good runs hold only inside a defect, the bad pointer run only outside one
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lf_q <= 1'b0;
            pf_q <= 1'b0;
            gap <= 0;
            lgood <= 0;
            pbad <= 0;
            pgood <= 0;
        end else begin
            lf_q <= line_frame_i[0];
            pf_q <= path_frame_i;
            gap <= (l_frm && line_fas_ok_i[0]) ? 0 : gap + 1;
            lgood <= l_frm ? (line_fas_ok_i[0] ? lgood + 1 : 0) : (line_lof_o[0] ? lgood : 0);
            pbad <= p_frm ? (p_val ? 0 : pbad + 1) : (path_lop_o ? 0 : pbad);
            pgood <= p_frm ? (p_val ? pgood + 1 : 0) : (path_lop_o ? pgood : 0);
        end
    end
    sequence s_lof_set;
        $rose(line_lof_o[0]);
    endsequence
    sequence s_small_frm;
        p_frm && (path_rx_conc_i < path_prov_conc_i);
    endsequence
    chk_lof_not_early: assert property (s_lof_set |-> gap >= LOF_CYC - 5)
        else $error("line loss of frame came too early");
    chk_lof_by_deadline: assert property (gap > LOF_CYC + 6 |-> line_lof_o[0])
        else $error("line loss of frame missing after timeout");
    chk_lof_clear_two: assert property ($fell(line_lof_o[0]) |-> lgood >= 2)
        else $error("line loss of frame cleared too soon");
    chk_aps_on_lof: assert property (s_lof_set ##0 line_protected_i[0] |=> line_aps_req_o[0])
        else $error("no switch request on protected port");
    chk_lop_set_eight: assert property ($rose(path_lop_o) |-> pbad == 8)
        else $error("loss of pointer set at wrong frame");
    chk_lop_clear_three: assert property ($fell(path_lop_o) |-> pgood == 3)
        else $error("loss of pointer cleared at wrong frame");
    chk_conc_small: assert property (s_small_frm |-> ##[1:4] path_conc_mismatch_o)
        else $error("small payload not flagged");
    chk_pair_warn: assert property ((prov_b8zs_i != prov_esf_i) [*8] |-> prov_pair_warn_o)
        else $error("odd coding and framing pair not flagged");
endmodule : sfm_chk
bind sfm_defect_monitor sfm_chk #(
    .NUM_LINE(NUM_LINE),
    .CONC_W(CONC_W),
    .LOF_CYC(LOF_CYC)
) chk_u (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .line_frame_i(line_frame_i),
    .line_fas_ok_i(line_fas_ok_i),
    .line_protected_i(line_protected_i),
    .path_frame_i(path_frame_i),
    .path_ptr_ok_i(path_ptr_ok_i),
    .path_rx_conc_i(path_rx_conc_i),
    .path_prov_conc_i(path_prov_conc_i),
    .prov_b8zs_i(prov_b8zs_i),
    .prov_esf_i(prov_esf_i),
    .line_lof_o(line_lof_o),
    .line_aps_req_o(line_aps_req_o),
    .path_lop_o(path_lop_o),
    .path_conc_mismatch_o(path_conc_mismatch_o),
    .prov_pair_warn_o(prov_pair_warn_o)
);

// >>> verification/sfm_src_model.sv
`timescale 1ns/1ps
`include "sfm_params.svh"
module sfm_src_model (
    input wire logic clk_sys_i,
    output logic [1:0] line_frame_o,
    output logic [1:0] line_ok_o,
    output logic path_frame_o,
    output logic path_ok_o,
    output logic [`SFM_CONC_W-1:0] path_conc_o,
    output logic [1:0] ref_frame_o,
    output logic [1:0] ref_ok_o,
    output logic [1:0] ref_b8zs_o,
    output logic [1:0] ref_esf_o
);
    initial begin
        {line_frame_o, line_ok_o, path_frame_o, path_ok_o, path_conc_o} = '0;
        {ref_frame_o, ref_ok_o, ref_b8zs_o, ref_esf_o} = '0;
    end
    task automatic gap3();
        repeat (3) @(negedge clk_sys_i);
    endtask : gap3
    // Qualifiers turn over once their hold runs out, so a stale value never passes
    task automatic line_frm(input int p, input logic ok);
        @(negedge clk_sys_i);
        line_ok_o[p] = ok;
        line_frame_o[p] = 1'b1;
        gap3();
        line_frame_o[p] = 1'b0;
        gap3();
        line_ok_o[p] = ~ok;
    endtask : line_frm
    task automatic path_frm(input logic ok, input logic [`SFM_CONC_W-1:0] c);
        @(negedge clk_sys_i);
        {path_ok_o, path_conc_o} = {ok, c};
        path_frame_o = 1'b1;
        gap3();
        path_frame_o = 1'b0;
        gap3();
        {path_ok_o, path_conc_o} = ~{ok, c};
    endtask : path_frm
    task automatic ref_frm(input int p, input logic ok, input logic b8, input logic esf);
        @(negedge clk_sys_i);
        {ref_ok_o[p], ref_b8zs_o[p], ref_esf_o[p]} = {ok, b8, esf};
        ref_frame_o[p] = 1'b1;
        gap3();
        ref_frame_o[p] = 1'b0;
        gap3();
        {ref_ok_o[p], ref_b8zs_o[p], ref_esf_o[p]} = ~{ok, b8, esf};
    endtask : ref_frm
endmodule : sfm_src_model

// >>> verification/sfm_defect_monitor_test.sv
`timescale 1ns/1ps
module sfm_defect_monitor_test;
    localparam int LOF = 50;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [1:0] line_protected_i = 2'h1;
    logic [5:0] path_prov_conc_i = 6'h0c;
    logic prov_b8zs_i = 1'b1;
    logic prov_esf_i = 1'b1;
    wire logic [1:0] line_frame_i, line_fas_ok_i, ref_frame_i, ref_fas_ok_i;
    wire logic [1:0] ref_rx_b8zs_i, ref_rx_esf_i;
    wire logic path_frame_i, path_ptr_ok_i;
    wire logic [5:0] path_rx_conc_i;
    logic [1:0] line_lof_o, line_aps_req_o, ref_lof_o, ref_fmt_mismatch_o;
    logic path_lop_o, path_conc_mismatch_o, prov_pair_warn_o;
    int n_mismatch = 0;
    int n_compared = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    sfm_defect_monitor #(
        .LOF_CYC(LOF)
    ) dut_u (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .line_frame_i(line_frame_i),
        .line_fas_ok_i(line_fas_ok_i),
        .line_protected_i(line_protected_i),
        .path_frame_i(path_frame_i),
        .path_ptr_ok_i(path_ptr_ok_i),
        .path_rx_conc_i(path_rx_conc_i),
        .path_prov_conc_i(path_prov_conc_i),
        .ref_frame_i(ref_frame_i),
        .ref_fas_ok_i(ref_fas_ok_i),
        .ref_rx_b8zs_i(ref_rx_b8zs_i),
        .ref_rx_esf_i(ref_rx_esf_i),
        .prov_b8zs_i(prov_b8zs_i),
        .prov_esf_i(prov_esf_i),
        .line_lof_o(line_lof_o),
        .line_aps_req_o(line_aps_req_o),
        .path_lop_o(path_lop_o),
        .path_conc_mismatch_o(path_conc_mismatch_o),
        .ref_lof_o(ref_lof_o),
        .ref_fmt_mismatch_o(ref_fmt_mismatch_o),
        .prov_pair_warn_o(prov_pair_warn_o)
    );
    sfm_src_model src_u (
        .clk_sys_i(clk_sys_i),
        .line_frame_o(line_frame_i),
        .line_ok_o(line_fas_ok_i),
        .path_frame_o(path_frame_i),
        .path_ok_o(path_ptr_ok_i),
        .path_conc_o(path_rx_conc_i),
        .ref_frame_o(ref_frame_i),
        .ref_ok_o(ref_fas_ok_i),
        .ref_b8zs_o(ref_rx_b8zs_i),
        .ref_esf_o(ref_rx_esf_i)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc
    task automatic t_line();
        cyc(LOF + 10);
        chk(8'(line_lof_o), 8'h3);
        chk(8'(line_aps_req_o), 8'h1);
        src_u.line_frm(0, 1'b1);
        src_u.line_frm(0, 1'b0);
        src_u.line_frm(0, 1'b1);
        chk(8'(line_lof_o), 8'h3);
        src_u.line_frm(0, 1'b1);
        chk(8'(line_lof_o), 8'h2);
        cyc(2);
        chk(8'(line_aps_req_o), 8'h0);
        repeat (10) src_u.line_frm(0, 1'b1);
        chk(8'(line_lof_o), 8'h2);
        cyc(LOF - 15);
        chk(8'(line_lof_o), 8'h2);
        cyc(20);
        chk(8'(line_lof_o), 8'h3);
        $display("line test done");
    endtask : t_line
    task automatic t_path();
        logic [5:0] ok = 6'b111011;
        logic [5:0] lop = 6'b011111;
        logic [5:0] cz [6] = '{6'h0c, 6'h30, 6'h0c, 6'h0c, 6'h0c, 6'h30};
        for (int i = 0; i < 8; i++) begin
            src_u.path_frm(1'b1, (i < 4) ? 6'h01 : 6'h03);
            chk(8'(path_conc_mismatch_o), 8'h1);
            chk(8'(path_lop_o), 8'(i == 7));
        end
        for (int i = 0; i < 6; i++) begin
            src_u.path_frm(ok[i], cz[i]);
            chk(8'(path_lop_o), 8'(lop[i]));
        end
        chk(8'(path_conc_mismatch_o), 8'h0);
        $display("path test done");
    endtask : t_path
    task automatic t_ref();
        repeat (12) begin
            src_u.ref_frm(0, 1'b1, 1'b1, 1'b1);
            src_u.ref_frm(1, 1'b1, 1'b0, 1'b1);
        end
        chk(8'(ref_lof_o), 8'h2);
        chk(8'(ref_fmt_mismatch_o), 8'h2);
        src_u.ref_frm(1, 1'b1, 1'b1, 1'b0);
        chk(8'(ref_fmt_mismatch_o), 8'h2);
        src_u.ref_frm(1, 1'b1, 1'b1, 1'b1);
        src_u.ref_frm(1, 1'b1, 1'b1, 1'b1);
        chk(8'(ref_lof_o), 8'h0);
        chk(8'(ref_fmt_mismatch_o), 8'h0);
        $display("timing reference test done");
    endtask : t_ref
    task automatic t_prov();
        logic [3:0] warn = 4'b0110;
        for (int i = 0; i < 4; i++) begin
            prov_b8zs_i = i[1];
            prov_esf_i = i[0];
            cyc(8);
            chk(8'(prov_pair_warn_o), 8'(warn[i]));
        end
        prov_b8zs_i = 1'b0;
        prov_esf_i = 1'b0;
        cyc(4);
        src_u.ref_frm(0, 1'b1, 1'b0, 1'b0);
        src_u.ref_frm(1, 1'b1, 1'b1, 1'b1);
        chk(8'(ref_fmt_mismatch_o), 8'h2);
        $display("provisioning test done");
    endtask : t_prov
    task automatic tally_and_finish();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        cyc(5);
        rst_b_i = 1'b1;
        t_line();
        t_path();
        t_ref();
        t_prov();
        tally_and_finish();
    end
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : sfm_defect_monitor_test
